// file: ulr_dir_ctl.sv
// RS-485 direction pin drive with turnaround delay and polarity
`timescale 1ns/1ps
module ulr_dir_ctl (
	input  wire logic                       clk_in,
	input  wire logic                       resetn_in,
	input  wire logic                       auto_mode_in,
	input  wire logic                       active_level_in,
	input  wire logic                       sw_level_in,
	input  wire logic                       tx_active_in,
	input  wire logic [ulr_pkg::DLY_W-1:0]  delay_in,
	input  wire logic [ulr_pkg::BIT_W-1:0]  bit_len_in,
	output logic                            pin_out,
	output logic                            state_out
);
	import ulr_pkg::*;

	logic             hold_reg;
	logic [BIT_W-1:0] clk_cnt_reg;
	logic [DLY_W-1:0] bit_cnt_reg;

	wire bit_tick  = clk_cnt_reg >= bit_len_in - 1'b1;
	wire hold_end  = delay_in == '0 || (bit_tick && bit_cnt_reg == delay_in - 1'b1);
	wire drive_on  = tx_active_in || hold_reg;
	wire auto_lvl  = active_level_in ? drive_on : !drive_on;
	wire sw_lvl    = active_level_in ? sw_level_in : !sw_level_in;
	wire pin_next  = auto_mode_in ? auto_lvl : sw_lvl;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			hold_reg    <= 1'b0;
			clk_cnt_reg <= '0;
			bit_cnt_reg <= '0;
			pin_out     <= 1'b0;
			state_out   <= 1'b0;
		end else begin
			pin_out   <= pin_next; // see R17 // see R18 // see R19
			state_out <= pin_next; // see R18
			if (tx_active_in) begin
				hold_reg    <= 1'b1;
				clk_cnt_reg <= '0;
				bit_cnt_reg <= '0;
			end else if (hold_reg) begin // see R13
				if (hold_end) begin
					hold_reg <= 1'b0;
				end
				clk_cnt_reg <= bit_tick ? '0 : clk_cnt_reg + 1'b1;
				if (bit_tick) begin
					bit_cnt_reg <= bit_cnt_reg + 1'b1;
				end
			end
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	a_dir_software: assert property (!auto_mode_in |=> pin_out == ($past(active_level_in) ? $past(sw_level_in) : !$past(sw_level_in))) else $error("software level wrong"); // see R19
	a_dir_transmit: assert property (auto_mode_in && tx_active_in |=> pin_out == $past(active_level_in)) else $error("pin not active in transmit"); // see R17
endmodule : ulr_dir_ctl

// file: ulr_lin_master.sv
// LIN master model: break pulse, delimiter, then sync byte
`timescale 1ns/1ps
module ulr_lin_master (
	input  wire logic       clk_in,
	input  wire logic       go_in,
	input  wire logic [7:0] bit_in,
	output logic            line_out,
	output logic            brk_out
);
	localparam logic [9:0] SYNC_FRAME = 10'h2AA;
	initial begin
		line_out = 1'h1;
		brk_out = 1'h0;
		forever begin
			@(posedge clk_in);
			if (go_in) begin
				#5 brk_out = 1'h1;
				@(posedge clk_in);
				#5 brk_out = 1'h0;
				repeat (2 * bit_in) @(posedge clk_in);
				// Start, 0x55 lsb first, stop, each one bit long
				for (int i = 0; i < 10; i++) begin
					#5 line_out = SYNC_FRAME[i];
					repeat (bit_in) @(posedge clk_in);
				end
			end
		end
	end
endmodule : ulr_lin_master

// file: ulr_pkg.sv
// Shared constants and types for the LIN slave, RS-485 and DMA request block
package ulr_pkg;
	localparam logic [1:0] FUNC_LIN       = 2'h1;
	localparam logic [1:0] FUNC_RS485     = 2'h3;
	localparam int         DIV_W          = 16;
	localparam int         CNT_W          = 13;
	localparam int         BIT_W          = DIV_W + 1;
	localparam int         DLY_W          = 8;
	localparam int         BAUD_OFFSET    = 2;
	localparam int         HDR_TOUT_BITS  = 57;
	localparam int         SYNC_EDGES     = 5;
	localparam int         SYNC_BITS      = 8;
	localparam int         EDGE_BITS      = 2;
	localparam logic [7:0] SYNC_BYTE      = 8'h55;
	// Check one limit 37/256 = 14.45 %, check two limit 11/64 = 17.19 %
	localparam int         DEV1_NUM       = 37;
	localparam int         DEV1_SHIFT     = 8;
	localparam int         DEV2_NUM       = 11;
	localparam int         DEV2_SHIFT     = 6;
	localparam logic [15:0] BAUD_RESET    = 16'h0000;

	typedef enum logic [1:0] {HDR_IDLE, HDR_SYNC, HDR_ID, HDR_HOLD} ulr_hdr_state_t;
endpackage : ulr_pkg

// file: ulr_sync_meas.sv
// Sync field measurement with overflow and two deviation checks
`timescale 1ns/1ps
module ulr_sync_meas (
	input  wire logic                       clk_in,
	input  wire logic                       resetn_in,
	input  wire logic                       start_in,
	input  wire logic                       abort_in,
	input  wire logic                       fall_in,
	input  wire logic [ulr_pkg::BIT_W-1:0]  bit_len_in,
	output logic                            done_out,
	output logic [ulr_pkg::DIV_W-1:0]       new_div_out,
	output logic                            dev_err_out,
	output logic                            ovf_err_out
);
	import ulr_pkg::*;

	logic             active_reg;
	logic [2:0]       edges_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] last_reg;
	logic             dev2_reg;

	wire              counting  = active_reg && edges_reg != 3'h0;
	wire              at_max    = cnt_reg == {CNT_W{1'b1}};
	wire [CNT_W-1:0]  iv        = cnt_reg - last_reg;
	wire [19:0]       nom2      = 20'(bit_len_in) * 20'(EDGE_BITS);
	wire [19:0]       nom8      = 20'(bit_len_in) * 20'(SYNC_BITS);
	wire [19:0]       d2        = (20'(iv) > nom2) ? 20'(iv) - nom2 : nom2 - 20'(iv);
	wire [19:0]       d8        = (20'(cnt_reg) > nom8) ? 20'(cnt_reg) - nom8 : nom8 - 20'(cnt_reg);
	wire              dev2_hit  = (28'(d2) << DEV2_SHIFT) > 28'(nom2) * 28'(DEV2_NUM);
	wire              dev1_hit  = (28'(d8) << DEV1_SHIFT) > 28'(nom8) * 28'(DEV1_NUM);
	wire              last_edge = counting && fall_in && edges_reg == 3'(SYNC_EDGES - 1);
	wire [CNT_W-1:0]  per_bit   = cnt_reg >> 3;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			active_reg  <= 1'b0;
			edges_reg   <= 3'h0;
			cnt_reg     <= '0;
			last_reg    <= '0;
			dev2_reg    <= 1'b0;
			done_out    <= 1'b0;
			new_div_out <= '0;
			dev_err_out <= 1'b0;
			ovf_err_out <= 1'b0;
		end else begin
			done_out    <= 1'b0;
			dev_err_out <= 1'b0;
			ovf_err_out <= 1'b0;
			if (abort_in) begin
				active_reg <= 1'b0;
			end else if (start_in) begin
				active_reg <= 1'b1;
				edges_reg  <= 3'h0;
				cnt_reg    <= '0;
				last_reg   <= '0;
				dev2_reg   <= 1'b0;
			end else if (active_reg && fall_in && edges_reg == 3'h0) begin
				edges_reg <= 3'h1;
				cnt_reg   <= CNT_W'(1); // First edge clock belongs to the span
			end else if (last_edge) begin // see R2
				active_reg  <= 1'b0;
				done_out    <= 1'b1;
				new_div_out <= DIV_W'(per_bit) - DIV_W'(BAUD_OFFSET); // see R24
				dev_err_out <= dev1_hit || dev2_hit || dev2_reg; // see R7 // see R8
			end else if (counting && at_max) begin // see R3
				active_reg  <= 1'b0;
				ovf_err_out <= 1'b1;
			end else if (counting) begin
				cnt_reg <= cnt_reg + 1'b1;
				if (fall_in) begin
					edges_reg <= edges_reg + 1'b1;
					last_reg  <= cnt_reg;
					dev2_reg  <= dev2_reg || dev2_hit; // see R8
				end
			end
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	a_meas_overflow: assert property (counting && at_max && !fall_in && !abort_in && !start_in |=> ovf_err_out && !active_reg) else $error("overflow not flagged"); // see R3
	a_meas_done_once: assert property (done_out |=> !done_out && !active_reg) else $error("done repeated"); // see R2
endmodule : ulr_sync_meas

// file: ulr_top.sv
// LIN slave resync, RS-485 modes and DMA request generation
// Overview of operation
// R1 - Software sets divider, selects LIN function, chooses resync, then enables slave.
// R2 - With resync, time five sync falling edges on 13 bits, load divider.
// R3 - Measurement counter overflow before fifth edge sets the header error flag.
// R4 - Reload enable restores saved divider on next character, then clears itself.
// R5 - Header research write restores saved divider and restarts header search.
// R6 - Software must use divider mode 2 whenever resynchronisation is on.
// R7 - Whole sync span deviation above 14.84 percent flags error, below 14.06 never.
// R8 - Per interval deviation above 18.75 percent flags error, below 15.62 never.
// R9 - Header detection enable runs hardware header search; errors raise LIN interrupt.
// R10 - Short delimiter, frame error, bad sync byte, deviation or timeouts flag error; the sync byte value is checked only with resync off.
// R11 - Software selects RS-485 function; transmit and receive otherwise plain.
// R12 - Ninth bit one marks address; stick parity sends inverse of even select.
// R13 - Direction pin released turnaround delay bit times after last stop bit.
// R14 - Multidrop with receiver off drops data until address, then stores and interrupts.
// R15 - Multidrop with receiver on stores every character, even before any address.
// R16 - Auto address stores from matching address until a non-matching address.
// R17 - Auto direction drives the direction pin active during all transmit activity.
// R18 - Active level sets pin polarity; pin state reports the real level.
// R19 - Without auto direction, pin follows software level, inverted by active level.
// R20 - Transmit DMA enable issues requests while the transmit FIFO has room.
// R21 - Receive DMA enable issues requests while the receive FIFO holds data.
// R22 - Character in progress is stored even when the DMA channel stops.
// R23 - Header timeout starts at break; 57 bit times without header flags error.
// R24 - Resynced divider is measured span over eight bits, minus mode 2 offset.
`timescale 1ns/1ps
module ulr_top (
	input  wire logic                       clk_in,
	input  wire logic                       resetn_in,
	input  wire logic [1:0]                 function_select_in,
	input  wire logic                       lin_slave_enable_in,
	input  wire logic                       auto_resync_enable_in,
	input  wire logic                       header_detect_enable_in,
	input  wire logic                       lin_irq_enable_in,
	input  wire logic                       baud_wr_in,
	input  wire logic [ulr_pkg::DIV_W-1:0]  baud_wdata_in,
	input  wire logic                       baud_mode_bit1_in,
	input  wire logic                       baud_mode_bit0_in,
	input  wire logic                       baud_reload_set_in,
	input  wire logic                       header_research_in,
	input  wire logic                       rx_line_in,
	input  wire logic                       break_det_in,
	input  wire logic                       delim_short_in,
	input  wire logic                       rx_char_valid_in,
	input  wire logic [7:0]                 rx_char_data_in,
	input  wire logic                       rx_char_bit9_in,
	input  wire logic                       rx_frame_err_in,
	input  wire logic                       parity_enable_in,
	input  wire logic                       even_parity_select_in,
	input  wire logic                       stick_parity_enable_in,
	input  wire logic [ulr_pkg::DLY_W-1:0]  turnaround_delay_in,
	input  wire logic                       multidrop_normal_mode_in,
	input  wire logic                       auto_address_mode_in,
	input  wire logic                       auto_direction_mode_in,
	input  wire logic                       receiver_off_wr_in,
	input  wire logic                       receiver_off_wdata_in,
	input  wire logic [7:0]                 address_match_value_in,
	input  wire logic                       direction_active_level_in,
	input  wire logic                       direction_sw_level_in,
	input  wire logic                       tx_active_in,
	input  wire logic                       tx_dma_request_enable_in,
	input  wire logic                       rx_dma_request_enable_in,
	input  wire logic                       tx_fifo_full_in,
	input  wire logic                       rx_fifo_empty_in,
	output logic [ulr_pkg::DIV_W-1:0]       baud_divider_out,
	output logic                            baud_reload_enable_out,
	output logic                            header_error_flag_out,
	output logic                            header_detect_flag_out,
	output logic                            lin_irq_out,
	output logic                            tx_ninth_bit_out,
	output logic                            receiver_off_out,
	output logic                            rx_store_out,
	output logic [8:0]                      rx_store_data_out,
	output logic                            address_irq_out,
	output logic                            direction_control_pin_out,
	output logic                            direction_pin_state_out,
	output logic                            tx_dma_req_out,
	output logic                            rx_dma_req_out
);
	import ulr_pkg::*;

	ulr_hdr_state_t   state_reg;
	ulr_hdr_state_t   state_next;
	logic [DIV_W-1:0] saved_baud_reg;
	logic [BIT_W-1:0] clk_cnt_reg;
	logic [5:0]       hdr_bits_reg;
	logic             rx_prev_reg;
	logic             match_reg;
	logic             meas_done;
	logic [DIV_W-1:0] meas_div;
	logic             meas_dev;
	logic             meas_ovf;
	logic             dir_pin;
	logic             dir_state;

	// Mode decode
	wire lin_mode   = function_select_in == FUNC_LIN && lin_slave_enable_in;
	wire rs485_mode = function_select_in == FUNC_RS485;
	wire resync_on  = lin_mode && auto_resync_enable_in;
	wire mode2      = baud_mode_bit1_in && baud_mode_bit0_in;

	// Bit timing from the live divider
	wire [BIT_W-1:0] bit_len  = BIT_W'(baud_divider_out) + BIT_W'(BAUD_OFFSET);
	wire             bit_tick = clk_cnt_reg >= bit_len - 1'b1;
	wire             rx_fall  = rx_prev_reg && !rx_line_in;

	// Header search
	wire in_header  = state_reg == HDR_SYNC || state_reg == HDR_ID;
	wire hdr_start  = lin_mode && header_detect_enable_in && break_det_in && state_reg != HDR_HOLD;
	wire hdr_tout   = in_header && bit_tick && hdr_bits_reg == 6'(HDR_TOUT_BITS - 1);
	wire sync_bad   = rx_frame_err_in || (!auto_resync_enable_in && rx_char_data_in != SYNC_BYTE);
	wire sync_err   = state_reg == HDR_SYNC && (delim_short_in || (rx_char_valid_in && sync_bad));
	wire id_err     = state_reg == HDR_ID && rx_char_valid_in && rx_frame_err_in;
	wire id_ok      = state_reg == HDR_ID && rx_char_valid_in && !rx_frame_err_in;
	wire meas_err   = resync_on && (meas_dev || meas_ovf);
	wire err_set    = sync_err || id_err || hdr_tout || meas_err;
	wire meas_start = resync_on && break_det_in;
	wire meas_load  = resync_on && meas_done && !meas_dev && mode2;

	// RS-485 receive filtering
	wire is_addr    = rx_char_bit9_in;
	wire addr_hit   = rx_char_data_in == address_match_value_in;
	wire nmm_store  = !receiver_off_out || is_addr;
	wire aad_store  = is_addr ? addr_hit : match_reg;
	wire rs_store   = auto_address_mode_in ? aad_store : (multidrop_normal_mode_in ? nmm_store : 1'b1);
	wire store_w    = rx_char_valid_in && (!rs485_mode || rs_store);
	wire receiver_off_clr  = rs485_mode && multidrop_normal_mode_in && rx_char_valid_in && is_addr;

	// Baud divider source selection
	wire reload_now = baud_reload_enable_out && rx_char_valid_in;
	wire [DIV_W-1:0] baud_next = baud_wr_in ? baud_wdata_in :
		(header_research_in || reload_now) ? saved_baud_reg :
		meas_load ? meas_div : baud_divider_out;
	wire hef_next   = err_set || (header_error_flag_out && !header_research_in);
	wire hdf_next   = (header_detect_flag_out && !break_det_in && !header_research_in) || id_ok;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			HDR_IDLE: begin
				if (hdr_start) begin
					state_next = HDR_SYNC;
				end
			end
			HDR_SYNC: begin
				if (err_set) begin
					state_next = HDR_HOLD;
				end else if (rx_char_valid_in) begin
					state_next = HDR_ID;
				end
			end
			HDR_ID: begin
				if (err_set) begin
					state_next = HDR_HOLD;
				end else if (id_ok) begin
					state_next = HDR_IDLE;
				end
			end
			HDR_HOLD: begin
				state_next = HDR_HOLD;
			end
		endcase
		if (header_research_in || !lin_mode) begin
			state_next = HDR_IDLE;
		end
	end

	ulr_sync_meas u_sync_meas (
		.clk_in      (clk_in),
		.resetn_in   (resetn_in),
		.start_in    (meas_start),
		.abort_in    (header_research_in),
		.fall_in     (rx_fall),
		.bit_len_in  (bit_len),
		.done_out    (meas_done),
		.new_div_out (meas_div),
		.dev_err_out (meas_dev),
		.ovf_err_out (meas_ovf)
	);

	ulr_dir_ctl u_dir_ctl (
		.clk_in          (clk_in),
		.resetn_in       (resetn_in),
		.auto_mode_in    (rs485_mode && auto_direction_mode_in),
		.active_level_in (direction_active_level_in),
		.sw_level_in     (direction_sw_level_in),
		.tx_active_in    (tx_active_in),
		.delay_in        (turnaround_delay_in),
		.bit_len_in      (bit_len),
		.pin_out         (dir_pin),
		.state_out       (dir_state)
	);

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_reg   <= HDR_IDLE;
			clk_cnt_reg <= '0;
			hdr_bits_reg <= '0;
			rx_prev_reg <= 1'b1;
		end else begin
			state_reg   <= state_next; // see R9
			rx_prev_reg <= rx_line_in;
			clk_cnt_reg <= (bit_tick || break_det_in) ? '0 : clk_cnt_reg + 1'b1;
			if (break_det_in) begin // see R23
				hdr_bits_reg <= '0;
			end else if (in_header && bit_tick) begin
				hdr_bits_reg <= hdr_bits_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			baud_divider_out       <= BAUD_RESET;
			saved_baud_reg         <= BAUD_RESET;
			baud_reload_enable_out <= 1'b0;
			header_error_flag_out  <= 1'b0;
			header_detect_flag_out <= 1'b0;
			lin_irq_out            <= 1'b0;
		end else begin
			baud_divider_out       <= baud_next; // see R2 // see R4 // see R5
			saved_baud_reg         <= baud_wr_in ? baud_wdata_in : saved_baud_reg; // see R4
			baud_reload_enable_out <= baud_reload_set_in || (baud_reload_enable_out && !reload_now); // see R4
			header_error_flag_out  <= hef_next; // see R3 // see R10
			header_detect_flag_out <= hdf_next;
			lin_irq_out            <= lin_irq_enable_in && (hef_next || hdf_next); // see R9
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			match_reg         <= 1'b0;
			receiver_off_out  <= 1'b0;
			rx_store_out      <= 1'b0;
			rx_store_data_out <= 9'h000;
			address_irq_out   <= 1'b0;
			tx_ninth_bit_out  <= 1'b0;
			tx_dma_req_out    <= 1'b0;
			rx_dma_req_out    <= 1'b0;
		end else begin
			if (rx_char_valid_in && is_addr) begin // see R16
				match_reg <= addr_hit;
			end
			receiver_off_out  <= !receiver_off_clr && (receiver_off_wr_in ? receiver_off_wdata_in : receiver_off_out); // see R14
			rx_store_out      <= store_w; // see R14 // see R15 // see R16 // see R22
			rx_store_data_out <= store_w ? {rx_char_bit9_in, rx_char_data_in} : rx_store_data_out;
			address_irq_out   <= rs485_mode && multidrop_normal_mode_in && rx_char_valid_in && is_addr; // see R14
			tx_ninth_bit_out  <= parity_enable_in && stick_parity_enable_in && !even_parity_select_in; // see R12
			tx_dma_req_out    <= tx_dma_request_enable_in && !tx_fifo_full_in; // see R20
			rx_dma_req_out    <= rx_dma_request_enable_in && !rx_fifo_empty_in; // see R21
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			direction_control_pin_out <= 1'b0;
			direction_pin_state_out   <= 1'b0;
		end else begin
			direction_control_pin_out <= dir_pin; // see R17
			direction_pin_state_out   <= dir_state; // see R18
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	sequence s_reload_armed;
		baud_reload_enable_out && !baud_reload_set_in && !baud_wr_in && !header_research_in;
	endsequence

	sequence s_char_in;
		rx_char_valid_in;
	endsequence

	a_hef_sticky_set: assert property (err_set |=> header_error_flag_out) else $error("header error not set"); // see R10
	a_hef_research: assert property (header_research_in && !err_set |=> !header_error_flag_out) else $error("header error not cleared"); // see R5
	a_reload_restore: assert property (s_reload_armed ##0 s_char_in |=> baud_divider_out == $past(saved_baud_reg) && !baud_reload_enable_out) else $error("reload failed"); // see R4
	a_research_baud: assert property (header_research_in && !baud_wr_in |=> baud_divider_out == $past(saved_baud_reg) && state_reg == HDR_IDLE) else $error("research failed"); // see R5
	a_header_timeout: assert property (hdr_tout && !header_research_in && lin_mode |=> header_error_flag_out && state_reg == HDR_HOLD) else $error("timeout missed"); // see R23
	a_ninth_bit: assert property (parity_enable_in && stick_parity_enable_in |=> tx_ninth_bit_out == !$past(even_parity_select_in)) else $error("ninth bit wrong"); // see R12
	a_nmm_discard: assert property (rs485_mode && multidrop_normal_mode_in && !auto_address_mode_in && receiver_off_out && rx_char_valid_in && !is_addr |=> !rx_store_out) else $error("data not discarded"); // see R14
	a_nmm_address: assert property (receiver_off_clr && !auto_address_mode_in |=> rx_store_out && address_irq_out && !receiver_off_out) else $error("address not taken"); // see R14
	a_rx_dma_req: assert property (rx_dma_request_enable_in && !rx_fifo_empty_in |=> rx_dma_req_out) else $error("rx request missing"); // see R21
	a_irq_gate: assert property (!lin_irq_enable_in |=> !lin_irq_out) else $error("irq not masked"); // see R9
endmodule : ulr_top

// file: ulr_top_tb_top.sv
// Bench for LIN resync, RS-485 and DMA request logic
`timescale 1ns/1ps
module ulr_top_tb_top;
	import ulr_pkg::*;
	logic clk_in = '0, resetn_in = '0, lin_slave_enable_in = '0, auto_resync_enable_in = '0, go = '0;
	logic header_detect_enable_in = '0, lin_irq_enable_in = '0, baud_wr_in = '0, baud_mode_bit1_in = '0;
	logic baud_mode_bit0_in = '0, baud_reload_set_in = '0, header_research_in = '0, delim_short_in = '0;
	logic rx_char_valid_in = '0, rx_char_bit9_in = '0, rx_frame_err_in = '0, parity_enable_in = '0;
	logic even_parity_select_in = '0, stick_parity_enable_in = '0, multidrop_normal_mode_in = '0;
	logic auto_address_mode_in = '0, auto_direction_mode_in = '0, receiver_off_wr_in = '0, tx_active_in = '0;
	logic receiver_off_wdata_in = '0, direction_active_level_in = '0, direction_sw_level_in = '0;
	logic tx_dma_request_enable_in = '0, rx_dma_request_enable_in = '0, tx_fifo_full_in = '0, rx_fifo_empty_in = '0;
	logic [1:0] function_select_in = '0;
	logic [7:0] rx_char_data_in = '0, turnaround_delay_in = '0, address_match_value_in = '0, bit_len = '0;
	logic [DIV_W-1:0] baud_wdata_in = '0;
	logic [DIV_W-1:0] baud_divider_out;
	logic [8:0] rx_store_data_out;
	logic rx_line_in, break_det_in, baud_reload_enable_out, header_error_flag_out, header_detect_flag_out;
	logic lin_irq_out, tx_ninth_bit_out, receiver_off_out, rx_store_out, address_irq_out, tx_dma_req_out;
	logic direction_control_pin_out, direction_pin_state_out, rx_dma_req_out;
	int n_mismatch = 0;
	int n_checks = 0;
	ulr_top dut (.*);
	ulr_lin_master master (.clk_in(clk_in), .go_in(go), .bit_in(bit_len), .line_out(rx_line_in),
		.brk_out(break_det_in));
	initial
		forever #25 clk_in = ~clk_in;
	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
		#5;
	endtask : step
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test();
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	// Bounded wait on the error flag (sel) or the divider
	task automatic wait_val(input logic sel, input logic [15:0] exp);
		logic [15:0] v;
		for (int i = 0; i < 600; i++) begin
			v = sel ? {15'h0000, header_error_flag_out} : baud_divider_out;
			if (v === exp)
				break;
			step(1);
		end
		chk(v, exp);
		if (v !== exp)
			finish_test();
	endtask : wait_val
	// Zero bit length pulses header research, else starts a master header
	task automatic sync(input logic [7:0] b);
		bit_len = b;
		{header_research_in, go} = {b == 8'h00, b != 8'h00};
		step(1);
		{header_research_in, go} = 2'h0;
	endtask : sync
	task automatic rx_chk(input logic [8:0] c, input logic st);
		step(1);
		{rx_char_bit9_in, rx_char_data_in} = c;
		rx_char_valid_in = 1'h1;
		step(1);
		rx_char_valid_in = 1'h0;
		chk(rx_store_out, st);
		if (st)
			chk(rx_store_data_out, c);
	endtask : rx_chk
	task automatic t_lin();
		function_select_in = FUNC_LIN;
		baud_wdata_in = 16'h000F;
		baud_wr_in = 1'h1;
		step(1);
		baud_wr_in = 1'h0;
		chk(baud_divider_out, 16'h000F);
		{baud_mode_bit1_in, baud_mode_bit0_in, auto_resync_enable_in} = 3'h7;
		{header_detect_enable_in, lin_irq_enable_in, lin_slave_enable_in} = 3'h7;
		sync(8'h12);
		wait_val(1'h0, 16'h0010);
		chk(header_error_flag_out, 1'h0);
		rx_chk(9'h055, 1'h1);
		rx_chk(9'h023, 1'h1);
		chk(header_detect_flag_out, 1'h1);
		chk(lin_irq_out, 1'h1);
		baud_reload_set_in = 1'h1;
		step(1);
		baud_reload_set_in = 1'h0;
		chk(baud_reload_enable_out, 1'h1);
		rx_chk(9'h011, 1'h1);
		chk(baud_divider_out, 16'h000F);
		chk(baud_reload_enable_out, 1'h0);
		step(40);
		sync(8'h00);
		sync(8'h16);
		wait_val(1'h1, 16'h0001);
		chk(lin_irq_out, 1'h1);
		sync(8'h00);
		chk(header_error_flag_out, 1'h0);
		auto_resync_enable_in = 1'h0;
		step(50);
		sync(8'h11);
		rx_chk(9'h054, 1'h1);
		chk(header_error_flag_out, 1'h1);
		lin_slave_enable_in = 1'h0;
	endtask : t_lin
	task automatic t_rs485();
		function_select_in = FUNC_RS485;
		{multidrop_normal_mode_in, receiver_off_wdata_in, receiver_off_wr_in} = 3'h7;
		step(1);
		receiver_off_wr_in = 1'h0;
		rx_chk(9'h012, 1'h0);
		rx_chk(9'h1A5, 1'h1);
		chk(address_irq_out, 1'h1);
		chk(receiver_off_out, 1'h0);
		rx_chk(9'h033, 1'h1);
		{multidrop_normal_mode_in, auto_address_mode_in, address_match_value_in} = {2'h1, 8'h5A};
		rx_chk(9'h044, 1'h0);
		rx_chk(9'h15A, 1'h1);
		rx_chk(9'h066, 1'h1);
		rx_chk(9'h1A5, 1'h0);
		rx_chk(9'h077, 1'h0);
		for (int i = 0; i < 8; i++) begin
			{parity_enable_in, stick_parity_enable_in, even_parity_select_in} = i[2:0];
			step(1);
			chk(tx_ninth_bit_out, i == 6);
		end
	endtask : t_rs485
	task automatic t_dir();
		{auto_direction_mode_in, direction_active_level_in, tx_active_in} = 3'h7;
		turnaround_delay_in = 8'h02;
		step(3);
		chk(direction_control_pin_out, 1'h1);
		tx_active_in = 1'h0;
		step(28);
		chk(direction_control_pin_out, 1'h1);
		step(30);
		chk(direction_control_pin_out, 1'h0);
		auto_direction_mode_in = 1'h0;
		for (int i = 0; i < 4; i++) begin
			{direction_active_level_in, direction_sw_level_in} = i[1:0];
			step(3);
			chk(direction_control_pin_out, i == 0 || i == 3);
			chk(direction_pin_state_out, i == 0 || i == 3);
		end
	endtask : t_dir
	initial begin
		step(5);
		resetn_in = 1'h1;
		chk(baud_divider_out, BAUD_RESET);
		t_lin();
		t_rs485();
		t_dir();
		for (int i = 0; i < 16; i++) begin
			{tx_dma_request_enable_in, tx_fifo_full_in, rx_dma_request_enable_in, rx_fifo_empty_in} = i[3:0];
			step(1);
			chk(tx_dma_req_out, i[3] & ~i[2]);
			chk(rx_dma_req_out, i[1] & ~i[0]);
		end
		finish_test();
	end
endmodule : ulr_top_tb_top
